/* logic/exc_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the design files
`ifndef EXC_DEFINES_SVH
`define EXC_DEFINES_SVH
`define BWS_OFFSET      2'h0
`define RCS_OFFSET      2'h1
`define BFC_OFFSET      2'h2
`define BWS_BIT         1
`define BFC_BIT         7
`define RC_POR_BIT      7
`define RC_PIN_BIT      6
`define RC_WDG_BIT      5
`define RC_ILLEGAL_OPCODE_FLAG_BIT     4
`define RC_ILLEGAL_ADDRESS_FLAG_BIT     3
`define RC_LVI_BIT      1
`define REG_RESET       8'h00
`define LONG_RECOVERY   13'h1000
`define SHORT_RECOVERY  13'h0020
`define SWI_VECTOR      4'h0
`endif

/* logic/exc_pkg.sv */
// types shared by the exception unit
// state codes are written out here; nothing is taken from exc_defines.svh
package exc_pkg;
    typedef enum logic [2:0] {
        ST_RUN     = 3'h0,
        ST_STACK   = 3'h1,
        ST_WAIT    = 3'h3,
        ST_STOP    = 3'h2,
        ST_RECOVER = 3'h6
    } state_t;
endpackage

/* logic/exception_and_low_power_control.sv */
// exception, break and low-power sequencing beside an 8-bit cpu core
// assumes the core pulses instruction completion and obeys the entry strobe
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "exc_defines.svh"
module exception_and_low_power_control #(
    parameter int NUM_IRQ = 8,
    parameter int VEC_W   = 4
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    // register port
    input  wire logic [1:0]         i_addr,
    input  wire logic [7:0]         i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [7:0]         o_rdata,
    // cpu core
    input  wire logic               i_instr_done,
    input  wire logic               i_mask_bit,
    input  wire logic [15:0]        i_pc,
    input  wire logic               i_swi_exec,
    input  wire logic               i_rti_exec,
    input  wire logic               i_wait_exec,
    input  wire logic               i_stop_exec,
    output logic                    o_entry,
    output logic      [VEC_W-1:0]   o_vector_sel,
    output logic      [15:0]        o_stack_pc,
    output logic                    o_stack_high_index,
    output logic                    o_set_mask,
    output logic                    o_clear_mask,
    // interrupt sources
    input  wire logic [NUM_IRQ-1:0] i_irq_req,
    input  wire logic [NUM_IRQ-1:0] i_irq_en,
    // break module
    input  wire logic               i_break_req,
    output logic                    o_break_state,
    output logic                    o_flag_clear_en,
    // reset sources
    input  wire logic               i_por,
    input  wire logic               i_ext_rst_n,
    input  wire logic               i_watchdog_rst,
    input  wire logic               i_illegal_opcode,
    input  wire logic               i_illegal_address,
    input  wire logic               i_low_voltage,
    output logic                    o_reset_req,
    // configuration straps
    input  wire logic               i_watchdog_disable,
    input  wire logic               i_short_recovery_select,
    // clock gating
    output logic                    o_cpu_clk_en,
    output logic                    o_bus_clk_en,
    output logic                    o_osc_clk_en,
    output logic                    o_watchdog_run
);

    // =======================================================
    // pin synchroniser
    logic [2:0]            ext_sync_r;
    logic                  ext_low_r;
    logic                  any_reset;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ext_sync_r <= 3'h7;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], i_ext_rst_n};
        end
    end

    // a glitch seen only in one stage is not taken as a reset
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ext_low_r <= 1'b0;
        end else if (ext_sync_r[1] == ext_sync_r[2]) begin
            ext_low_r <= ~ext_sync_r[2];
        end
    end

    assign any_reset = i_por | ext_low_r | i_watchdog_rst |
                       i_illegal_opcode | i_illegal_address | i_low_voltage;
    assign o_reset_req = any_reset;

    // =======================================================
    // arbitration
    logic [NUM_IRQ-1:0]    live;
    logic [NUM_IRQ-1:0]    higher;
    logic [NUM_IRQ-1:0]    winner;
    logic [VEC_W-1:0]      win_code;
    logic                  hw_pending;

    assign live = i_irq_req & i_irq_en;
    assign higher[0] = 1'b0;
    genvar g;
    generate
        for (g = 0; g < NUM_IRQ; g++) begin : g_arb
            if (g > 0) begin : g_hi
                assign higher[g] = higher[g-1] | live[g-1];
            end
            assign winner[g] = live[g] & ~higher[g];
        end
    endgenerate

    always_comb begin
        win_code = `SWI_VECTOR;
        for (int k = NUM_IRQ - 1; k >= 0; k--) begin
            if (winner[k]) begin
                win_code = VEC_W'(k + 1);
            end
        end
    end

    assign hw_pending = (|live) & ~i_mask_bit;

    // =======================================================
    // sequencer
    exc_pkg::state_t       state_r;
    exc_pkg::state_t       state_nxt;
    logic [VEC_W-1:0]      vec_r;
    logic [15:0]           pc_r;
    logic [12:0]           rec_cnt_r;
    logic [12:0]           rec_len;
    logic                  break_state_r;
    logic                  stop_wake;

    assign rec_len = i_short_recovery_select ? `SHORT_RECOVERY
                                             : `LONG_RECOVERY;
    assign stop_wake = |i_irq_req;

    always_comb begin
        state_nxt = state_r;
        if (any_reset) begin
            state_nxt = exc_pkg::ST_RUN;
        end else begin
            unique case (state_r)
                exc_pkg::ST_RUN: begin
                    if (i_break_req || i_swi_exec) begin
                        state_nxt = exc_pkg::ST_STACK;
                    end else if (i_wait_exec) begin
                        state_nxt = exc_pkg::ST_WAIT;
                    end else if (i_stop_exec) begin
                        state_nxt = exc_pkg::ST_STOP;
                    end else if (i_instr_done && hw_pending) begin
                        state_nxt = exc_pkg::ST_STACK;
                    end
                end
                exc_pkg::ST_STACK: begin
                    state_nxt = exc_pkg::ST_RUN;
                end
                exc_pkg::ST_WAIT: begin
                    if (i_break_req || (|live)) begin
                        state_nxt = exc_pkg::ST_STACK;
                    end
                end
                exc_pkg::ST_STOP: begin
                    if (stop_wake) begin
                        state_nxt = exc_pkg::ST_RECOVER;
                    end
                end
                exc_pkg::ST_RECOVER: begin
                    if (rec_cnt_r == rec_len - 13'h0001) begin
                        state_nxt = exc_pkg::ST_STACK;
                    end
                end
                default: begin
                    state_nxt = exc_pkg::ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= exc_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // the choice is frozen once latched, so a later higher request waits
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || any_reset) begin
            vec_r <= `SWI_VECTOR;
            pc_r  <= 16'h0000;
        end else if (state_nxt == exc_pkg::ST_STACK &&
                     state_r != exc_pkg::ST_STACK &&
                     state_r != exc_pkg::ST_RECOVER) begin
            if (i_break_req || i_swi_exec) begin
                vec_r <= `SWI_VECTOR;
                pc_r  <= i_pc;
            end else begin
                vec_r <= win_code;
                pc_r  <= i_pc - 16'h0001;
            end
        end else if (state_r == exc_pkg::ST_STOP && stop_wake) begin
            vec_r <= win_code;
            pc_r  <= i_pc - 16'h0001;
        end
    end

    // counter sits at zero through stop and only runs in recovery
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || state_r != exc_pkg::ST_RECOVER) begin
            rec_cnt_r <= 13'h0000;
        end else begin
            rec_cnt_r <= rec_cnt_r + 13'h0001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || any_reset) begin
            break_state_r <= 1'b0;
        end else if (i_break_req && state_r != exc_pkg::ST_STOP &&
                     state_r != exc_pkg::ST_RECOVER) begin
            break_state_r <= 1'b1;
        end else if (i_rti_exec) begin
            break_state_r <= 1'b0;
        end
    end

    // in run only i_instr_done lets a pending request in; a return does not count as completion
    assign o_entry            = (state_r == exc_pkg::ST_STACK);
    assign o_set_mask         = o_entry;
    assign o_stack_high_index = 1'b0;
    assign o_vector_sel       = vec_r;
    assign o_stack_pc         = pc_r;
    assign o_clear_mask       = ~any_reset &&
                                (state_r == exc_pkg::ST_RUN) &&
                                (i_wait_exec || i_stop_exec);
    assign o_cpu_clk_en       = (state_r == exc_pkg::ST_RUN) ||
                                (state_r == exc_pkg::ST_STACK);
    assign o_bus_clk_en       = (state_r != exc_pkg::ST_STOP) &&
                                (state_r != exc_pkg::ST_RECOVER);
    assign o_osc_clk_en       = (state_r != exc_pkg::ST_STOP);
    assign o_watchdog_run     = ~i_watchdog_disable &&
                                (state_r != exc_pkg::ST_STOP) &&
                                (state_r != exc_pkg::ST_RECOVER);
    assign o_break_state      = break_state_r;

    // =======================================================
    // registers
    logic                  bw_r;
    logic                  break_clear_enable_r;
    logic [7:0]            cause_r;
    logic [7:0]            cause_set;
    logic [7:0]            rdata_r;

    always_comb begin
        cause_set = 8'h00;
        cause_set[`RC_POR_BIT]  = i_por;
        cause_set[`RC_PIN_BIT]  = ext_low_r;
        cause_set[`RC_WDG_BIT]  = i_watchdog_rst & ~i_watchdog_disable;
        cause_set[`RC_ILLEGAL_OPCODE_FLAG_BIT] = i_illegal_opcode;
        cause_set[`RC_ILLEGAL_ADDRESS_FLAG_BIT] = i_illegal_address;
        cause_set[`RC_LVI_BIT]  = i_low_voltage;
    end

    // a cause that lands in the read cycle is kept: set beats clear
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cause_r <= `REG_RESET;
        end else if (i_por) begin
            cause_r <= cause_set;
        end else if (i_rd && i_addr == `RCS_OFFSET) begin
            cause_r <= cause_set;
        end else begin
            cause_r <= cause_r | cause_set;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || any_reset) begin
            bw_r <= 1'b0;
        end else if (state_r == exc_pkg::ST_WAIT && i_break_req) begin
            bw_r <= 1'b1;
        end else if (i_wr && i_addr == `BWS_OFFSET &&
                     !i_wdata[`BWS_BIT]) begin
            bw_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || any_reset) begin
            break_clear_enable_r <= 1'b0;
        end else if (i_wr && i_addr == `BFC_OFFSET) begin
            break_clear_enable_r <= i_wdata[`BFC_BIT];
        end
    end

    // outside break every clear passes; inside only with the enable
    assign o_flag_clear_en = ~break_state_r | break_clear_enable_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_r <= `REG_RESET;
        end else begin
            rdata_r <= 8'h00;
            if (i_rd) begin
                unique case (i_addr)
                    `BWS_OFFSET: rdata_r[`BWS_BIT] <= bw_r;
                    `RCS_OFFSET: rdata_r <= cause_r;
                    `BFC_OFFSET: rdata_r[`BFC_BIT] <= break_clear_enable_r;
                    default:     rdata_r <= 8'h00;
                endcase
            end
        end
    end
    assign o_rdata = rdata_r;

    // =======================================================
    // checks
    sequence wait_break_s;
        state_r == exc_pkg::ST_WAIT && i_break_req && !any_reset;
    endsequence
    sequence stop_wake_s;
        state_r == exc_pkg::ST_STOP && stop_wake && !any_reset;
    endsequence

    // cycles since the waking request; a counter stands in for a long repeat
    logic [12:0]           rec_seen_r;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || any_reset || o_entry) begin
            rec_seen_r <= 13'h0000;
        end else if (state_r == exc_pkg::ST_STOP && stop_wake) begin
            rec_seen_r <= 13'h0001;
        end else if (rec_seen_r != 13'h0000) begin
            rec_seen_r <= rec_seen_r + 13'h0001;
        end
    end

    entry_sets_mask_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) o_entry |-> o_set_mask && !o_stack_high_index)
        else $error("entry without mask set");
    masked_no_entry_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) state_r == exc_pkg::ST_RUN && i_mask_bit &&
        !i_swi_exec && !i_break_req |=> !o_entry)
        else $error("entry while masked");
    swi_entry_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) state_r == exc_pkg::ST_RUN && i_swi_exec &&
        !any_reset |=> o_entry && o_vector_sel == `SWI_VECTOR &&
        o_stack_pc == $past(i_pc))
        else $error("swi entry wrong");
    hw_pc_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) state_r == exc_pkg::ST_RUN && i_instr_done &&
        hw_pending && !i_swi_exec && !i_break_req && !i_wait_exec &&
        !i_stop_exec && !any_reset |=> o_entry &&
        o_stack_pc == $past(i_pc) - 16'h0001)
        else $error("hardware pc not minus one");
    reset_wins_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) any_reset |=> !o_entry)
        else $error("entry during reset");
    wait_break_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) wait_break_s |=> bw_r && o_entry)
        else $error("break in wait lost");
    stop_recover_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) o_entry && rec_seen_r != 13'h0000 |->
        rec_seen_r == (i_short_recovery_select ? `SHORT_RECOVERY
                                               : `LONG_RECOVERY) + 13'h0001)
        else $error("stop recovery length wrong");
    stop_late_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) rec_seen_r <=
        (i_short_recovery_select ? `SHORT_RECOVERY
                                 : `LONG_RECOVERY) + 13'h0001)
        else $error("stop recovery too long");
    stop_no_early_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) stop_wake_s |=> !o_entry[*8])
        else $error("stop recovery too short");
    cause_read_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) i_rd && i_addr == `RCS_OFFSET &&
        cause_set == 8'h00 |=> cause_r == 8'h00 && o_rdata == $past(cause_r))
        else $error("reset cause not cleared");
    break_clear_a: assert property (@(posedge i_clk)
        disable iff (i_sys_rst) break_state_r && !break_clear_enable_r |-> !o_flag_clear_en)
        else $error("flag clear open in break");

endmodule

/* testbench/core_model.sv */
// cpu core stand-in: keeps the interrupt mask and a program counter
// assumes the exception unit's clock and its synchronous reset
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // exception unit side
    input  wire logic        i_set_mask,
    input  wire logic        i_clear_mask,
    // program side
    input  wire logic        i_step,
    input  wire logic        i_unmask,
    output logic             o_mask,
    output logic [15:0]      o_pc
);
    // ============================================================
    // mask and program counter
    // mask leaves reset set, as a real core does, so no hardware interrupt is taken
    // until the bench unmasks on purpose
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mask <= 1'b1;
        end else if (i_set_mask) begin
            o_mask <= 1'b1;
        end else if (i_clear_mask || i_unmask) begin
            o_mask <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pc <= 16'h8000;
        end else if (i_step) begin
            o_pc <= o_pc + 16'h0001;
        end
    end
endmodule

/* testbench/tb_exception_and_low_power_control.sv */
// self-checking bench for the exception and low-power unit
// assumes the core model beside it and a 100 MHz clock
`timescale 1ns/1ps
module tb_exception_and_low_power_control;
    // ============================================================
    // stimulus and observed nets
    logic        i_clk = 1'b0;
    logic        rst   = 1'b1;
    logic [1:0]  addr  = 2'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [5:0]  ev    = 6'h00;
    logic [5:0]  src   = 6'h00;
    logic [7:0]  irq   = 8'h00;
    logic [7:0]  en    = 8'hff;
    logic        wdis  = 1'b0;
    logic        ssel  = 1'b1;
    logic        last_cm;
    logic [15:0] pc0;
    logic [7:0]  rdata;
    logic [3:0]  vec;
    logic [15:0] spc;
    logic        entry, hidx, setm, clrm, brk_st, fce, rreq;
    logic        cpu_en, bus_en, osc_en, wdg_run, mask;
    logic [15:0] pc;
    int          errors = 0;
    int          comparisons = 0;
    int          n;

    always #5 i_clk = ~i_clk;

    core_model core (
        .i_clk(i_clk), .i_sys_rst(rst), .i_set_mask(setm),
        .i_clear_mask(clrm), .i_step(ev[0]), .i_unmask(ev[2]),
        .o_mask(mask), .o_pc(pc)
    );

    exception_and_low_power_control dut (
        .i_clk(i_clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_instr_done(ev[0]),
        .i_mask_bit(mask), .i_pc(pc), .i_swi_exec(ev[1]),
        .i_rti_exec(ev[2]), .i_wait_exec(ev[3]), .i_stop_exec(ev[4]),
        .o_entry(entry), .o_vector_sel(vec), .o_stack_pc(spc),
        .o_stack_high_index(hidx), .o_set_mask(setm), .o_clear_mask(clrm),
        .i_irq_req(irq), .i_irq_en(en), .i_break_req(ev[5]),
        .o_break_state(brk_st), .o_flag_clear_en(fce), .i_por(src[5]),
        .i_ext_rst_n(~src[4]), .i_watchdog_rst(src[3]),
        .i_illegal_opcode(src[2]), .i_illegal_address(src[1]),
        .i_low_voltage(src[0]), .o_reset_req(rreq),
        .i_watchdog_disable(wdis), .i_short_recovery_select(ssel),
        .o_cpu_clk_en(cpu_en), .o_bus_clk_en(bus_en),
        .o_osc_clk_en(osc_en), .o_watchdog_run(wdg_run)
    );

    // ============================================================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_clk);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_clk);
        rd   <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, exp});
    endtask

    // one-cycle core or break event; checks land after the sampling edge
    task automatic fire(input logic [5:0] e);
        @(posedge i_clk);
        ev <= e;
        #1 last_cm = clrm;
        @(posedge i_clk);
        ev <= 6'h00;
        #1;
    endtask

    // reset sources held long enough to pass the pin filter, then let go
    // long enough for the filter to drop, so a later read clears the cause
    task automatic rs(input logic [5:0] s);
        @(posedge i_clk);
        src <= s;
        repeat (6) @(posedge i_clk);
        chk({15'h0, rreq}, 16'h0001);
        src <= 6'h00;
        repeat (5) @(posedge i_clk);
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ============================================================
    // watchdog: the long stop recovery dominates the run time
    initial begin
        repeat (20000) @(posedge i_clk);
        errors++;
        tally_and_finish();
    end

    // ============================================================
    // tests
    initial begin
        repeat (4) @(posedge i_clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            rd_reg(a[1:0], 8'h00);
        end
        wr_reg(2'h3, 8'hff);
        rd_reg(2'h3, 8'h00);
        fire(6'h04);
        irq <= 8'h28;
        en  <= 8'h00;
        fire(6'h01);
        chk({15'h0, entry}, 16'h0000);
        en  <= 8'hff;
        pc0 = pc;
        fire(6'h01);
        chk({11'h0, entry, vec}, 16'h0014);
        chk(spc, pc0 - 16'h0001);
        chk({14'h0, setm, hidx}, 16'h0002);
        irq <= 8'h20;
        fire(6'h01);
        chk({15'h0, entry}, 16'h0000);
        fire(6'h04);
        fire(6'h01);
        chk({11'h0, entry, vec}, 16'h0016);
        irq <= 8'h00;
        pc0 = pc;
        fire(6'h02);
        chk({11'h0, entry, vec}, 16'h0010);
        chk(spc, pc0);
        fire(6'h20);
        chk({11'h0, entry, vec}, 16'h0010);
        chk({14'h0, brk_st, fce}, 16'h0002);
        wr_reg(2'h2, 8'h80);
        #1 chk({15'h0, fce}, 16'h0001);
        rd_reg(2'h2, 8'h80);
        wr_reg(2'h2, 8'h00);
        fire(6'h04);
        chk({14'h0, brk_st, fce}, 16'h0001);
        fire(6'h08);
        chk({15'h0, last_cm}, 16'h0001);
        chk({13'h0, cpu_en, bus_en, wdg_run}, 16'h0003);
        irq <= 8'h01;
        @(posedge i_clk);
        #1 chk({11'h0, entry, vec}, 16'h0011);
        irq  <= 8'h00;
        wdis <= 1'b1;
        fire(6'h08);
        chk({15'h0, wdg_run}, 16'h0000);
        fire(6'h20);
        chk({15'h0, entry}, 16'h0001);
        rd_reg(2'h0, 8'h02);
        wr_reg(2'h0, 8'hff);
        rd_reg(2'h0, 8'h02);
        wr_reg(2'h0, 8'h00);
        rd_reg(2'h0, 8'h00);
        fire(6'h04);
        // short then long recovery; the count runs from the waking request
        for (int i = 0; i < 2; i++) begin
            ssel <= (i == 0);
            fire(6'h10);
            chk({14'h0, osc_en, bus_en}, 16'h0000);
            repeat (3) @(posedge i_clk);
            irq <= 8'h04;
            n = 0;
            do begin
                @(posedge i_clk);
                #1 n++;
            end while (entry !== 1'b1 && n < 5000);
            chk({15'h0, n >= ((i == 0) ? 32 : 4096)}, 16'h0001);
            chk({15'h0, n <= ((i == 0) ? 34 : 4098)}, 16'h0001);
            chk({12'h0, vec}, 16'h0003);
            irq <= 8'h00;
            fire(6'h04);
        end
        rs(6'h10);
        rd_reg(2'h1, 8'h40);
        rd_reg(2'h1, 8'h00);
        rs(6'h0b);
        rd_reg(2'h1, 8'h0a);
        wdis <= 1'b0;
        rs(6'h0c);
        rd_reg(2'h1, 8'h30);
        rs(6'h01);
        rs(6'h20);
        rd_reg(2'h1, 8'h80);
        rd_reg(2'h1, 8'h00);
        tally_and_finish();
    end
endmodule
